// *** mpc_pkg.sv ***
// shared types and constants for the external bus pin controller
package mpc_pkg;
	// --------------------------------------------------------------
	// widths and bus timing
	// --------------------------------------------------------------
	localparam int ADDR_W      = 20;
	localparam int DATA_W      = 8;
	localparam int IO_ADDR_W   = 16;
	localparam int IRQ_N       = 3;
	localparam int DMA_N       = 2;
	localparam int A18_BIT     = 18;
	localparam int MC_T_STATES = 3;
	localparam logic [1:0] T_FIRST = 2'h0;
	localparam logic [1:0] T_WRITE = 2'h1;
	localparam logic [1:0] T_LAST  = 2'(MC_T_STATES - 1);
	localparam logic [15:0] NMI_VECTOR = 16'h0066;
	localparam logic [ADDR_W-1:0] ADDR_SLEEP = '1;
	localparam logic [IRQ_N-1:0] SRC_ONE = 3'h2;
	localparam logic [IRQ_N-1:0] SRC_TWO = 3'h4;

	// --------------------------------------------------------------
	// enumerations
	// --------------------------------------------------------------
	typedef enum logic [2:0] {
		K_FETCH, K_MEMRD, K_MEMWR, K_IORD, K_IOWR, K_REFRESH, K_ACK0, K_ACK12
	} mpc_kind_e;

	typedef enum logic [2:0] {
		S_IDLE, S_CYC, S_FLOAT, S_GRANT, S_HALT, S_SLEEP
	} mpc_fsm_e;

	// --------------------------------------------------------------
	// carriers
	// --------------------------------------------------------------
	typedef struct packed {
		logic                  valid;
		mpc_kind_e             kind;
		logic [ADDR_W-1:0]     addr;
		logic [DATA_W-1:0]     wdata;
		logic                  last;
		logic                  halt;
		logic                  sleep;
		logic [IRQ_N-1:0]      ie;
	} mpc_core_req_s;

	typedef struct packed {
		logic                  taken;
		logic                  done;
		logic [DATA_W-1:0]     rdata;
		logic                  nmi_take;
		logic [15:0]           vector;
		logic [IRQ_N-1:0]      irq_take;
	} mpc_core_rsp_s;

	typedef struct packed {
		logic [1:0]            toc;
		logic                  timer_out;
		logic [1:0]            cka_out;
		logic [1:0]            baud_clk;
		logic                  async_clock_one_transfer_done_zero_n;
		logic                  async_clock_zero_dma_request_zero_n;
		logic                  cks_out;
		logic                  cks_clk;
		logic [DMA_N-1:0]      dreq_edge;
		logic                  clear_to_send_one_n_sel;
		logic                  request_to_send_zero_n;
		logic [1:0]            txa;
		logic                  sync_serial_tx;
		logic [DMA_N-1:0]      tend;
	} mpc_cfg_s;

	typedef struct packed {
		logic                  bus_grant_request_n_n;
		logic                  nmi_n;
		logic [IRQ_N-1:0]      irq_n;
		logic                  dma_request_one_n_n;
		logic                  clear_to_send_zero_n_n;
		logic                  carrier_detect_zero_n_n;
		logic                  sync_serial_rx;
		logic [1:0]            rxa;
		logic [1:0]            cka_i;
		logic                  cks_i;
		logic [DATA_W-1:0]     data_i;
	} mpc_pin_in_s;

	typedef struct packed {
		logic [ADDR_W-1:0]     addr;
		logic [ADDR_W-1:0]     addr_oe;
		logic [DATA_W-1:0]     data;
		logic                  data_oe;
		logic                  strobe_oe;
		logic                  memory_cycle_n_n;
		logic                  io_cycle_n_n;
		logic                  rd_n;
		logic                  wr_n;
		logic                  m1_n;
		logic                  dram_refresh_n_n;
		logic                  halt_n;
		logic                  bus_grant_ack_n_n;
		logic                  st;
		logic                  e;
		logic                  request_to_send_zero_n_n;
		logic [1:0]            txa;
		logic                  sync_serial_tx;
		logic                  transfer_done_one_n_n;
		logic [1:0]            cka_o;
		logic [1:0]            cka_oe;
		logic                  cks_o;
		logic                  cks_oe;
	} mpc_pin_out_s;

	typedef struct packed {
		logic [DMA_N-1:0]      dma_req;
		logic [1:0]            cts;
		logic                  carrier_detect_zero_n;
		logic                  sync_serial_rx;
		logic [1:0]            rxa;
		logic [1:0]            ext_cka;
		logic                  ext_cks;
	} mpc_periph_s;

	typedef struct packed {
		mpc_fsm_e              fsm;
		logic [1:0]            tcnt;
		mpc_kind_e             kind;
		logic [ADDR_W-1:0]     addr;
		logic [DATA_W-1:0]     wdata;
		logic                  last;
		logic                  halt;
		logic                  sleep;
		logic [IRQ_N-1:0]      ack_src;
		logic                  nmi_prev;
		logic                  nmi_pend;
		logic [DMA_N-1:0]      dreq_prev;
		mpc_pin_out_s          pins;
		mpc_core_rsp_s         rsp;
		mpc_periph_s           per;
	} mpc_state_s;

	// --------------------------------------------------------------
	// reset values
	// --------------------------------------------------------------
	localparam mpc_pin_in_s PIN_IN_IDLE = '1;

	localparam mpc_pin_out_s PINS_RST = '{
		strobe_oe: 1'b1, memory_cycle_n_n: 1'b1, io_cycle_n_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
		m1_n: 1'b1, dram_refresh_n_n: 1'b1, halt_n: 1'b1, bus_grant_ack_n_n: 1'b1, st: 1'b1,
		request_to_send_zero_n_n: 1'b1, txa: 2'h3, sync_serial_tx: 1'b1, transfer_done_one_n_n: 1'b1, default: '0
	};
endpackage

// *** mpc_sync.sv ***
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module mpc_sync #(
	parameter int         W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         i_ref_clk,
	input  wire logic         i_nrst,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	import mpc_pkg::*;

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] q;
	} mpc_sync_s;

	mpc_sync_s s_r;
	mpc_sync_s s_nxt;

	// meta feeds only the second stage
	always_comb begin
		s_nxt.meta = i_d;
		s_nxt.q    = s_r.meta;
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			s_r <= '{meta: RST_VAL, q: RST_VAL};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_q = s_r.q;
endmodule

// *** mpc_pin_ctrl.sv ***
// external bus, interrupt and pin-state controller
`timescale 1ns/1ps
// Function
// - drive 20-bit address, 16 lines for I/O
// - float address in reset and bus grant
// - line 18 shared with timer, reset selects address
// - timer output when either control bit set
// - 8-bit data bus floats reset/grant
// - grant bus request at machine-cycle end, before NMI
// - float bus, then assert acknowledge
// - async clock pins output or input
// - DMA requests level or edge sensed
// - enable clock marks bus machine cycles
// - halt low while halted or sleeping
// - irq_zero_n ack cycle with opcode and I/O
// - irq_one_n/irq_two_n only when higher sources idle
// - irq_one_n/irq_two_n ack without opcode or I/O
// - I/O request for I/O or irq_zero_n ack
// - opcode cycle with memory or I/O request
// - memory request only for memory cycles
// - reset pin levels and floated clocks
// - grant pin levels and floated strobes
// - sleep pin levels, data floated
// - clear-to-send inputs, second shares receive pin
// - NMI falling edge jumps to 0066h
module mpc_pin_ctrl (
	input  wire logic            i_ref_clk,
	input  wire logic            i_nrst,
	input  mpc_pkg::mpc_core_req_s i_core,
	input  mpc_pkg::mpc_cfg_s      i_cfg,
	input  mpc_pkg::mpc_pin_in_s   i_pins,
	output mpc_pkg::mpc_pin_out_s  o_pins,
	output mpc_pkg::mpc_core_rsp_s o_rsp,
	output mpc_pkg::mpc_periph_s   o_periph
);
	import mpc_pkg::*;

	// --------------------------------------------------------------
	// state and input synchronisation
	// --------------------------------------------------------------
	localparam mpc_state_s STATE_RST = '{
		fsm: S_IDLE, kind: K_FETCH, pins: PINS_RST, nmi_prev: 1'b1,
		dreq_prev: '1, default: '0
	};

	mpc_state_s        s_r;
	mpc_state_s        s_nxt;
	mpc_pin_in_s       sy;
	logic              breq;
	logic              nmi_fall;
	logic              nmi_act;
	logic              mc_end;
	logic [IRQ_N-1:0]  irq;

	mpc_sync #(
		.W       ($bits(mpc_pin_in_s)),
		.RST_VAL (PIN_IN_IDLE)
	) u_sync (
		.i_ref_clk (i_ref_clk),
		.i_nrst    (i_nrst),
		.i_d       (i_pins),
		.o_q       (sy)
	);

	assign breq     = ~sy.bus_grant_request_n_n;
	assign nmi_fall = s_r.nmi_prev & ~sy.nmi_n;
	assign nmi_act  = s_r.nmi_pend | nmi_fall;
	assign irq      = ~sy.irq_n & i_core.ie;
	assign mc_end   = (s_r.fsm == S_CYC) && (s_r.tcnt == T_LAST);

	// --------------------------------------------------------------
	// next state
	// --------------------------------------------------------------
	always_comb begin
		mpc_pin_out_s p;
		logic         accept;
		logic         take_nmi;
		logic         bus;
		logic         ext;
		logic         is_io;
		logic         is_mem;
		logic         is_rd;
		logic         is_wr;
		logic [DMA_N-1:0] dreq_cur;
		p        = s_r.pins;
		accept   = 1'b0;
		take_nmi = 1'b0;
		bus      = 1'b0;
		ext      = 1'b0;
		is_io    = 1'b0;
		is_mem   = 1'b0;
		is_rd    = 1'b0;
		is_wr    = 1'b0;
		dreq_cur = '0;
		s_nxt    = s_r;
		s_nxt.rsp.taken    = 1'b0;
		s_nxt.rsp.done     = 1'b0;
		s_nxt.rsp.nmi_take = 1'b0;
		s_nxt.rsp.irq_take = '0;
		s_nxt.nmi_prev     = sy.nmi_n;

		case (s_r.fsm)
			S_IDLE: begin
				if (breq) begin
					s_nxt.fsm = S_FLOAT;
				end else if (i_core.valid) begin
					s_nxt.fsm       = S_CYC;
					s_nxt.tcnt      = T_FIRST;
					s_nxt.kind      = i_core.kind;
					s_nxt.addr      = i_core.addr;
					s_nxt.wdata     = i_core.wdata;
					s_nxt.last      = i_core.last;
					s_nxt.halt      = i_core.halt;
					s_nxt.sleep     = i_core.sleep;
					s_nxt.rsp.taken = 1'b1;
				end
			end
			S_CYC: begin
				s_nxt.tcnt = s_r.tcnt + 2'h1;
				if (mc_end) begin
					s_nxt.fsm = S_IDLE;
					if (s_r.kind == K_ACK0 || s_r.kind == K_ACK12) begin
						s_nxt.rsp.irq_take = s_r.ack_src;
					end else begin
						s_nxt.rsp.done = 1'b1;
					end
					if (s_r.kind inside {K_FETCH, K_MEMRD, K_IORD, K_ACK0}) begin
						s_nxt.rsp.rdata = sy.data_i;
					end
					if (breq) begin
						s_nxt.fsm = S_FLOAT;
					end else begin
						accept = s_r.last;
					end
				end
			end
			S_HALT, S_SLEEP: begin
				accept = 1'b1;
			end
			S_FLOAT: begin
				s_nxt.fsm = S_GRANT;
			end
			S_GRANT: begin
				if (!breq) begin
					s_nxt.fsm = S_IDLE;
				end
			end
			default: begin
				s_nxt.fsm = S_IDLE;
			end
		endcase

		if (accept) begin
			if (nmi_act) begin
				take_nmi = 1'b1;
				s_nxt.fsm = S_IDLE;
			end else if (irq != '0) begin
				s_nxt.fsm     = S_CYC;
				s_nxt.tcnt    = T_FIRST;
				s_nxt.last    = 1'b0;
				s_nxt.halt    = 1'b0;
				s_nxt.sleep   = 1'b0;
				s_nxt.kind    = irq[0] ? K_ACK0 : K_ACK12;
				s_nxt.ack_src = irq[0] ? 3'h1 : (irq[1] ? SRC_ONE : SRC_TWO);
			end else if (s_r.fsm == S_CYC) begin
				// enter halt or sleep after the instruction
				s_nxt.fsm = s_r.halt ? S_HALT : (s_r.sleep ? S_SLEEP : S_IDLE);
			end
		end
		// set wins over clear so a new edge is never lost
		s_nxt.nmi_pend     = take_nmi ? (s_r.nmi_pend & nmi_fall) : (s_r.nmi_pend | nmi_fall);
		s_nxt.rsp.nmi_take = take_nmi;
		if (take_nmi) begin
			s_nxt.rsp.vector = NMI_VECTOR;
		end

		// ----------------------------------------------------------
		// pin levels, derived from the next state
		// ----------------------------------------------------------
		bus    = (s_nxt.fsm == S_CYC);
		ext    = (s_nxt.fsm == S_FLOAT) || (s_nxt.fsm == S_GRANT);
		is_io  = s_nxt.kind inside {K_IORD, K_IOWR, K_ACK0};
		is_mem = s_nxt.kind inside {K_FETCH, K_MEMRD, K_MEMWR, K_REFRESH};
		is_rd  = s_nxt.kind inside {K_FETCH, K_MEMRD, K_IORD};
		is_wr  = s_nxt.kind inside {K_MEMWR, K_IOWR};

		// I/O cycles use only the low lines
		if (bus && s_nxt.kind != K_ACK12) begin
			if (is_io) begin
				p.addr = {{(ADDR_W-IO_ADDR_W){1'b0}}, s_nxt.addr[IO_ADDR_W-1:0]};
			end else begin
				p.addr = s_nxt.addr;
			end
		end else if (s_nxt.fsm == S_SLEEP) begin
			p.addr = ADDR_SLEEP;
		end
		p.addr_oe = ext ? '0 : '1;
		// shared line carries timer when selected
		if (i_cfg.toc != 2'h0) begin
			p.addr[A18_BIT]    = i_cfg.timer_out;
			p.addr_oe[A18_BIT] = 1'b1;
		end

		// data driven only by write cycles
		p.data    = s_nxt.wdata;
		p.data_oe = bus && is_wr;

		p.strobe_oe = ~ext;
		p.memory_cycle_n_n = ~(bus && is_mem);
		p.io_cycle_n_n = ~(bus && is_io);
		p.rd_n   = ~(bus && is_rd);
		p.wr_n   = ~(bus && is_wr && s_nxt.tcnt >= T_WRITE);
		p.m1_n   = ~((bus && s_nxt.kind inside {K_FETCH, K_ACK0}) ||
			(s_nxt.fsm == S_HALT));
		p.dram_refresh_n_n = ~(bus && s_nxt.kind == K_REFRESH);
		p.halt_n = ~((s_nxt.fsm == S_HALT) || (s_nxt.fsm == S_SLEEP));
		p.bus_grant_ack_n_n = ~(s_nxt.fsm == S_GRANT);
		p.st = ~((bus && s_nxt.kind == K_FETCH) || (s_nxt.fsm == S_HALT));
		// enable clock high over the later T-states
		p.e = bus && (s_nxt.tcnt != T_FIRST);

		p.request_to_send_zero_n_n  = ~i_cfg.request_to_send_zero_n;
		p.txa     = i_cfg.txa;
		p.sync_serial_tx     = i_cfg.sync_serial_tx;
		p.transfer_done_one_n_n = ~i_cfg.tend[1];
		// baud clock out, or float to accept one
		p.cka_o[0]  = i_cfg.baud_clk[0];
		p.cka_oe[0] = i_cfg.cka_out[0] && !i_cfg.async_clock_zero_dma_request_zero_n;
		if (i_cfg.async_clock_one_transfer_done_zero_n) begin
			// transfer end held high in grant
			p.cka_o[1]  = ext ? 1'b1 : ~i_cfg.tend[0];
			p.cka_oe[1] = 1'b1;
		end else begin
			p.cka_o[1]  = i_cfg.baud_clk[1];
			p.cka_oe[1] = i_cfg.cka_out[1];
		end
		p.cks_o  = i_cfg.cks_clk;
		p.cks_oe = i_cfg.cks_out;
		s_nxt.pins = p;

		// ----------------------------------------------------------
		// peripheral side of the pins
		// ----------------------------------------------------------
		dreq_cur = {sy.dma_request_one_n_n, (i_cfg.async_clock_zero_dma_request_zero_n ? sy.cka_i[0] : 1'b1)};
		// edge sensing gives a one-clock pulse
		for (int i = 0; i < DMA_N; i++) begin
			if (i_cfg.dreq_edge[i]) begin
				s_nxt.per.dma_req[i] = s_r.dreq_prev[i] & ~dreq_cur[i];
			end else begin
				s_nxt.per.dma_req[i] = ~dreq_cur[i];
			end
		end
		s_nxt.dreq_prev = dreq_cur;
		// second clear-to-send shares the receive pin
		s_nxt.per.cts[0] = ~sy.clear_to_send_zero_n_n;
		s_nxt.per.cts[1] = i_cfg.clear_to_send_one_n_sel & ~sy.sync_serial_rx;
		s_nxt.per.sync_serial_rx     = i_cfg.clear_to_send_one_n_sel ? 1'b1 : sy.sync_serial_rx;
		s_nxt.per.carrier_detect_zero_n    = ~sy.carrier_detect_zero_n_n;
		s_nxt.per.rxa     = sy.rxa;
		s_nxt.per.ext_cka = sy.cka_i;
		s_nxt.per.ext_cks = sy.cks_i;
	end

	// --------------------------------------------------------------
	// registers
	// --------------------------------------------------------------
	// every pin takes its reset level
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			s_r <= STATE_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_pins   = s_r.pins;
	assign o_rsp    = s_r.rsp;
	assign o_periph = s_r.per;

	// --------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);

	sequence s_grant_point;
		breq && mc_end;
	endsequence

	sequence s_irq_zero_n_win;
		mc_end && s_r.last && !breq && !nmi_act && irq[0];
	endsequence

	sequence s_ack0_cycle;
		(!o_pins.m1_n && !o_pins.io_cycle_n_n)[*3] ##1 o_rsp.irq_take[0];
	endsequence

	property p_grant_late;
		s_grant_point |=> ##1 !o_pins.bus_grant_ack_n_n;
	endproperty
	a_grant_late: assert property (p_grant_late) else $error("grant late");

	property p_float_first;
		$fell(o_pins.bus_grant_ack_n_n) |-> !$past(o_pins.data_oe) && !$past(o_pins.strobe_oe)
			&& ($past(o_pins.addr_oe) & ~(20'h1 << A18_BIT)) == '0;
	endproperty
	a_float_first: assert property (p_float_first) else $error("bus not floated");

	property p_addr_float;
		!o_pins.bus_grant_ack_n_n |-> (o_pins.addr_oe & ~(20'h1 << A18_BIT)) == '0;
	endproperty
	a_addr_float: assert property (p_addr_float) else $error("address driven");

	property p_data_float;
		!o_pins.bus_grant_ack_n_n |-> !o_pins.data_oe && !o_pins.strobe_oe && o_pins.m1_n;
	endproperty
	a_data_float: assert property (p_data_float) else $error("data driven");

	property p_reset_levels;
		$rose(i_nrst) |-> !o_pins.e && o_pins.rd_n && o_pins.wr_n && o_pins.bus_grant_ack_n_n
			&& o_pins.halt_n && o_pins.addr_oe == '0 && !o_pins.data_oe
			&& o_pins.cka_oe == '0 && !o_pins.cks_oe;
	endproperty
	a_reset_levels: assert property (p_reset_levels) else $error("reset level");

	property p_ack0;
		s_irq_zero_n_win |=> s_ack0_cycle;
	endproperty
	a_ack0: assert property (p_ack0) else $error("irq_zero_n ack wrong");

	property p_ack12_quiet;
		(s_r.fsm == S_CYC && s_r.kind == K_ACK12) |-> o_pins.m1_n && o_pins.io_cycle_n_n;
	endproperty
	a_ack12_quiet: assert property (p_ack12_quiet) else $error("ack12 strobe");

	property p_int12_blocked;
		(mc_end && s_r.last && (breq || nmi_act || irq[0])) |=> s_r.kind != K_ACK12;
	endproperty
	a_int12_blocked: assert property (p_int12_blocked) else $error("int12 early");

	property p_nmi_vector;
		(((mc_end && s_r.last && !breq) || s_r.fsm inside {S_HALT, S_SLEEP}) && nmi_act) |=>
			o_rsp.nmi_take && o_rsp.vector == NMI_VECTOR;
	endproperty
	a_nmi_vector: assert property (p_nmi_vector) else $error("nmi not taken");

	property p_io_mem_excl;
		!o_pins.io_cycle_n_n |-> o_pins.memory_cycle_n_n;
	endproperty
	a_io_mem_excl: assert property (p_io_mem_excl) else $error("io with memory_cycle_n");

	property p_timer_pin;
		($past(i_cfg.toc) != 2'h0) |-> o_pins.addr[A18_BIT] == $past(i_cfg.timer_out)
			&& o_pins.addr_oe[A18_BIT];
	endproperty
	a_timer_pin: assert property (p_timer_pin) else $error("timer pin wrong");

	property p_sleep_pins;
		(s_r.fsm == S_SLEEP) |-> !o_pins.halt_n && !o_pins.data_oe && o_pins.rd_n
			&& o_pins.wr_n && o_pins.memory_cycle_n_n && o_pins.io_cycle_n_n && o_pins.m1_n
			&& o_pins.dram_refresh_n_n;
	endproperty
	a_sleep_pins: assert property (p_sleep_pins) else $error("sleep pins");
endmodule

// *** mpc_ext_model.sv ***
// far-side model: memory, i/o, vector source and bus master
`timescale 1ns/1ps
module mpc_ext_model
	import mpc_pkg::*;
#(
	parameter logic [7:0] ACK_VEC = 8'h38
) (
	input  wire logic             i_ref_clk,
	input  mpc_pkg::mpc_pin_out_s i_pins,
	input  wire logic             i_want_bus,
	output logic                  o_bus_grant_request_n_n,
	output logic [7:0]            o_data
);
	logic [7:0] last_r = 8'h00;
	logic       ack0;
	logic       rd;

	assign o_bus_grant_request_n_n = ~i_want_bus;
	assign ack0 = i_pins.strobe_oe & ~i_pins.m1_n & ~i_pins.io_cycle_n_n;
	assign rd = i_pins.strobe_oe & ~i_pins.rd_n;

	// released bus toggles, never holds a stale byte
	always_comb begin
		if (ack0) begin
			o_data = ACK_VEC;
		end else if (rd) begin
			o_data = i_pins.addr[7:0] ^ 8'h3c;
		end else begin
			o_data = ~last_r;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		last_r <= o_data;
	end
endmodule

// *** tb_top.sv ***
// self-checking bench for the external bus pin controller
`timescale 1ns/1ps
module tb_top;
	import mpc_pkg::*;
	localparam logic [7:0] VEC = 8'h38;
	logic          ref_clk;
	logic          nrst;
	logic          want_bus;
	logic          nmi_n;
	logic [2:0]    irq_n;
	logic          bus_grant_request_n_n;
	logic [7:0]    ext_d;
	logic          ack0;
	logic          ackany;
	int            failures;
	int            checks;
	mpc_core_req_s core;
	mpc_cfg_s      cfg;
	mpc_pin_in_s   pin_in;
	mpc_pin_out_s  pout;
	mpc_core_rsp_s rsp;
	mpc_periph_s   per;
	logic          dma_request_one_n_n;
	logic          sync_serial_rx;

	// --------------------------------------------------------------
	// pins and instances
	// --------------------------------------------------------------
	// device drive wins the data wire, else the far side
	always_comb begin
		pin_in = PIN_IN_IDLE;
		pin_in.bus_grant_request_n_n = bus_grant_request_n_n;
		pin_in.nmi_n = nmi_n;
		pin_in.irq_n = irq_n;
		pin_in.dma_request_one_n_n = dma_request_one_n_n;
		pin_in.sync_serial_rx = sync_serial_rx;
		pin_in.data_i = pout.data_oe ? pout.data : ext_d;
	end

	mpc_pin_ctrl i_mpc_pin_ctrl (
		.i_ref_clk(ref_clk),
		.i_nrst(nrst),
		.i_core(core),
		.i_cfg(cfg),
		.i_pins(pin_in),
		.o_pins(pout),
		.o_rsp(rsp),
		.o_periph(per)
	);

	mpc_ext_model #(.ACK_VEC(VEC)) i_mpc_ext_model (
		.i_ref_clk(ref_clk),
		.i_pins(pout),
		.i_want_bus(want_bus),
		.o_bus_grant_request_n_n(bus_grant_request_n_n),
		.o_data(ext_d)
	);

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// --------------------------------------------------------------
	// shared tasks
	// --------------------------------------------------------------
	task automatic test_done();
		if (failures == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	task automatic step();
		@(posedge ref_clk);
		#1;
	endtask

	function automatic logic cond(input int w);
		case (w)
			0: return rsp.done === 1'b1;
			1: return pout.bus_grant_ack_n_n === 1'b0;
			2: return pout.bus_grant_ack_n_n === 1'b1;
			3: return (|rsp.irq_take) === 1'b1;
			4: return rsp.nmi_take === 1'b1;
			5: return pout.halt_n === 1'b0;
			6: return pout.halt_n === 1'b1;
			default: return rsp.taken === 1'b1;
		endcase
	endfunction

	// bounded wait; also notes which ack strobes showed up
	task automatic waitc(input int w);
		int n;
		n = 0;
		while (!cond(w)) begin
			step();
			n++;
			ack0 |= (pout.m1_n === 1'b0 && pout.io_cycle_n_n === 1'b0);
			ackany |= (pout.m1_n === 1'b0 || pout.io_cycle_n_n === 1'b0);
			if (n > 40) begin
				failures++;
				$display("CHECK FAILED at %0t: wait timed out", $time);
				test_done();
			end
		end
	endtask

	// valid held until taken is seen, then dropped
	task automatic run(input mpc_kind_e k, input logic [19:0] a, input logic l,
		input logic h, input logic s);
		core = '{valid:1'b1, kind:k, addr:a, wdata:8'h5a, last:l, halt:h, sleep:s, ie:3'h7};
		waitc(7);
		core.valid = 1'b0;
	endtask

	// --------------------------------------------------------------
	// scenarios
	// --------------------------------------------------------------
	task automatic t_reset_pins();
		chk(pout.addr_oe, 20'h0, "reset address float");
		chk({pout.data_oe, pout.strobe_oe, pout.e, pout.cka_oe, pout.cks_oe}, 6'h10, "reset oe");
		chk({pout.memory_cycle_n_n, pout.io_cycle_n_n, pout.rd_n, pout.wr_n, pout.m1_n, pout.dram_refresh_n_n,
			pout.halt_n, pout.bus_grant_ack_n_n, pout.st, pout.request_to_send_zero_n_n, pout.transfer_done_one_n_n, pout.txa,
			pout.sync_serial_tx}, 14'h3fff, "reset levels");
	endtask

	task automatic t_read();
		run(K_MEMRD, 20'hfffff, 1'b0, 1'b0, 1'b0);
		chk({pout.memory_cycle_n_n, pout.rd_n, pout.io_cycle_n_n, pout.wr_n, pout.e}, 5'h06, "read strobes");
		chk(pout.addr & pout.addr_oe, 20'hfffff, "full address");
		step();
		chk(pout.e, 1'b1, "enable clock");
		waitc(0);
		chk(rsp.rdata, 8'hff ^ 8'h3c, "read data");
	endtask

	task automatic t_io_write();
		run(K_IOWR, 20'hfabcd, 1'b0, 1'b0, 1'b0);
		chk({pout.memory_cycle_n_n, pout.io_cycle_n_n}, 2'h2, "io strobes");
		chk(pout.addr, 20'h0abcd, "io address");
		step();
		chk({pout.wr_n, pout.data_oe, pout.data}, 10'h15a, "write data");
		waitc(0);
	endtask

	task automatic t_fetch();
		run(K_FETCH, 20'h00100, 1'b0, 1'b0, 1'b0);
		chk({pout.m1_n, pout.memory_cycle_n_n, pout.io_cycle_n_n, pout.st}, 4'h2, "fetch status");
		waitc(0);
	endtask

	// request raised inside a cycle, so the grant falls at its end
	task automatic t_grant();
		cfg.toc = 2'h1;
		cfg.timer_out = 1'b1;
		run(K_MEMRD, 20'h00040, 1'b0, 1'b0, 1'b0);
		want_bus = 1'b1;
		waitc(1);
		chk({pout.addr_oe, pout.data_oe, pout.strobe_oe}, 22'h100000, "grant float");
		chk({pout.halt_n, pout.m1_n, pout.addr[18]}, 3'h7, "grant levels");
		want_bus = 1'b0;
		cfg.toc = 2'h0;
		waitc(2);
		step();
		chk(pout.addr_oe, 20'hfffff, "address driven again");
	endtask

	task automatic t_irq();
		irq_n = 3'h4;
		ack0 = 1'b0;
		run(K_MEMRD, 20'h00020, 1'b1, 1'b0, 1'b0);
		waitc(3);
		chk(rsp.irq_take, 3'h1, "highest irq first");
		chk(ack0, 1'b1, "zero ack strobes");
		chk(rsp.rdata, VEC, "vector byte");
		irq_n = 3'h5;
		ackany = 1'b0;
		run(K_MEMRD, 20'h00021, 1'b1, 1'b0, 1'b0);
		waitc(3);
		chk(rsp.irq_take, SRC_ONE, "irq one");
		chk(ackany, 1'b0, "quiet ack");
		irq_n = 3'h7;
	endtask

	task automatic t_halt();
		run(K_FETCH, 20'h00200, 1'b1, 1'b1, 1'b0);
		waitc(5);
		step();
		step();
		chk({pout.halt_n, pout.m1_n, pout.st}, 3'h0, "halted status");
		irq_n = 3'h3;
		waitc(3);
		chk(rsp.irq_take, SRC_TWO, "wake by irq two");
		irq_n = 3'h7;
		waitc(6);
	endtask

	task automatic t_sleep_nmi();
		run(K_MEMRD, 20'h00300, 1'b1, 1'b0, 1'b1);
		waitc(5);
		chk(pout.addr, ADDR_SLEEP, "sleep address");
		chk({pout.data_oe, pout.rd_n, pout.wr_n, pout.memory_cycle_n_n, pout.io_cycle_n_n, pout.dram_refresh_n_n,
			pout.m1_n, pout.st}, 8'h7f, "sleep levels");
		nmi_n = 1'b0;
		waitc(4);
		chk(rsp.vector, 16'h0066, "nmi vector");
		nmi_n = 1'b1;
		waitc(6);
		// one edge is taken once, not again at the next instruction end
		run(K_MEMRD, 20'h00301, 1'b1, 1'b0, 1'b0);
		waitc(0);
		chk(rsp.nmi_take, 1'b0, "nmi taken twice");
	endtask

	// pins shared with the serial and dma units
	task automatic t_periph();
		cfg.cka_out = 2'h1;
		cfg.baud_clk = 2'h1;
		cfg.async_clock_one_transfer_done_zero_n = 1'b1;
		cfg.tend = 2'h1;
		cfg.dreq_edge = 2'h2;
		cfg.clear_to_send_one_n_sel = 1'b1;
		dma_request_one_n_n = 1'b0;
		sync_serial_rx = 1'b0;
		step();
		chk({pout.cka_oe, pout.cka_o}, 4'hd, "async clock pins");
		repeat (2) step();
		chk(per.dma_req, 2'h2, "dma edge pulse");
		chk({per.cts, per.sync_serial_rx}, 3'h5, "shared receive pin");
		step();
		chk(per.dma_req, 2'h0, "edge pulse too long");
		cfg.dreq_edge = 2'h0;
		step();
		chk(per.dma_req, 2'h2, "dma level");
		cfg = '0;
		dma_request_one_n_n = 1'b1;
		sync_serial_rx = 1'b1;
	endtask

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		nrst = 1'b0;
		want_bus = 1'b0;
		nmi_n = 1'b1;
		irq_n = 3'h7;
		core = '0;
		dma_request_one_n_n = 1'b1;
		sync_serial_rx = 1'b1;
		cfg = '0;
		ack0 = 1'b0;
		ackany = 1'b0;
		failures = 0;
		checks = 0;
		repeat (12) @(posedge ref_clk);
		#1;
		t_reset_pins();
		nrst = 1'b1;
		step();
		t_read();
		t_io_write();
		t_fetch();
		t_grant();
		t_irq();
		t_halt();
		t_sleep_nmi();
		t_periph();
		// second reset in mid-run
		nrst = 1'b0;
		repeat (3) step();
		t_reset_pins();
		nrst = 1'b1;
		repeat (3) step();
		t_read();
		test_done();
	end
endmodule
